// [design/qcg_ctl.sv]
// clock controller end: drives the q-channel and the clock gate
module qcg_ctl #(
   parameter int RESTORE_CYC = qcg_pkg::CLK_RESTORE_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // q-channel toward the domain
   qcg_if.ctl q,
   // user side
   input wire logic stop_want,
   output logic clk_en,
   output logic running,
   output logic denied
);
   import qcg_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   qcg_ctl_st_t state_ff;
   qcg_ctl_st_t nxt_state;
   logic [SYNC_STAGES-1:0] acc_sync_ff;
   logic [SYNC_STAGES-1:0] deny_sync_ff;
   logic [SYNC_STAGES-1:0] act_sync_ff;
   logic acc_n_s;
   logic deny_s;
   logic act_s;
   logic [RESTORE_CNT_W-1:0] cnt_ff;
   logic qreq_n_ff;
   logic clk_en_ff;
   logic denied_ff;
   logic running_ff;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         acc_sync_ff <= {SYNC_STAGES{QACCEPT_N_RST}};
         deny_sync_ff <= '0;
         act_sync_ff <= '0;
      end else begin
         acc_sync_ff <= {acc_sync_ff[SYNC_STAGES-2:0], q.qaccept_n};
         deny_sync_ff <= {deny_sync_ff[SYNC_STAGES-2:0], q.qdeny};
         act_sync_ff <= {act_sync_ff[SYNC_STAGES-2:0], q.qactive};
      end
   end

   assign acc_n_s = acc_sync_ff[SYNC_STAGES-1];
   assign deny_s = deny_sync_ff[SYNC_STAGES-1];
   assign act_s = act_sync_ff[SYNC_STAGES-1];

   // ------------------------------------------------------------
   // handshake state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         QCG_CTL_STOPPED: begin
            if (act_s) begin
               nxt_state = QCG_CTL_RESTORE;
            end
         end
         QCG_CTL_RESTORE: begin
            // clock back before the request rises
            if (cnt_ff == RESTORE_CNT_W'(RESTORE_CYC - 1)) begin
               nxt_state = QCG_CTL_WAKE_REQ;
            end
         end
         QCG_CTL_WAKE_REQ: begin
            if (acc_n_s) begin
               nxt_state = QCG_CTL_RUN;
            end
         end
         QCG_CTL_RUN: begin
            if (stop_want && !act_s) begin
               nxt_state = QCG_CTL_STOP_REQ;
            end
         end
         QCG_CTL_STOP_REQ: begin
            if (!acc_n_s) begin
               nxt_state = QCG_CTL_STOPPED;
            end else if (deny_s) begin
               nxt_state = QCG_CTL_DENIED;
            end
         end
         QCG_CTL_DENIED: begin
            if (!deny_s) begin
               nxt_state = QCG_CTL_RUN;
            end
         end
         default: begin
            nxt_state = QCG_CTL_STOPPED;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= QCG_CTL_STOPPED;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= '0;
      end else if (state_ff == QCG_CTL_RESTORE) begin
         cnt_ff <= cnt_ff + RESTORE_CNT_W'(1);
      end else begin
         cnt_ff <= '0;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qreq_n_ff <= QREQ_N_RST;
      end else begin
         qreq_n_ff <= (nxt_state == QCG_CTL_WAKE_REQ) ||
                      (nxt_state == QCG_CTL_RUN) ||
                      (nxt_state == QCG_CTL_DENIED);
      end
   end

   // gate only once accepted, ungate first on wake
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clk_en_ff <= CLK_EN_RST;
      end else begin
         clk_en_ff <= (nxt_state != QCG_CTL_STOPPED);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         denied_ff <= 1'b0;
      end else begin
         denied_ff <= (nxt_state == QCG_CTL_DENIED);
      end
   end

   // running status straight from its own flop
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         running_ff <= 1'b0;
      end else begin
         running_ff <= (nxt_state == QCG_CTL_RUN);
      end
   end

   assign q.qreq_n = qreq_n_ff;
   assign clk_en = clk_en_ff;
   assign running = running_ff;
   assign denied = denied_ff;

endmodule : qcg_ctl

// [design/qcg_dev.sv]
// domain gating end: crossing unit plus domain clock control
module qcg_dev #(
   parameter int DW = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // q-channel toward the clock controller
   qcg_if.dev q,
   // upstream side
   input wire logic up_ok,
   input wire logic up_valid,
   input wire logic [DW-1:0] up_data,
   output logic up_ready,
   // downstream side
   output logic dn_valid,
   output logic [DW-1:0] dn_data,
   input wire logic dn_ready,
   input wire logic dn_busy,
   // status
   output logic isolated,
   output logic wake
);
   import qcg_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   qcg_dev_st_t state_ff;
   qcg_dev_st_t nxt_state;
   logic [SYNC_STAGES-1:0] qreq_sync_ff;
   logic [SYNC_STAGES-1:0] upok_sync_ff;
   logic int_qreq_n;
   logic up_ok_s;
   logic hold_v_ff;
   logic nxt_hold_v;
   logic [DW-1:0] hold_d_ff;
   logic up_ready_ff;
   logic qaccept_n_ff;
   logic qdeny_ff;
   logic qactive_ff;
   logic iso_ff;
   logic wake_ff;
   logic take;
   logic give;
   logic busy;
   logic arrival;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // external request crosses two flops before any decision
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qreq_sync_ff <= {SYNC_STAGES{QREQ_N_RST}};
      end else begin
         qreq_sync_ff <= {qreq_sync_ff[SYNC_STAGES-2:0], q.qreq_n};
      end
   end

   assign int_qreq_n = qreq_sync_ff[SYNC_STAGES-1];

   // upstream domain ready level, from another reset domain
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         upok_sync_ff <= '0;
      end else begin
         upok_sync_ff <= {upok_sync_ff[SYNC_STAGES-2:0], up_ok};
      end
   end

   assign up_ok_s = upok_sync_ff[SYNC_STAGES-1];

   // ------------------------------------------------------------
   // activity and transfers
   // ------------------------------------------------------------
   // upstream transactions only once upstream is ready
   assign arrival = up_valid && up_ok_s;
   assign take = arrival && up_ready_ff;
   assign give = hold_v_ff && dn_ready;
   // pending arrival counts as activity so it is never stranded
   assign busy = hold_v_ff || dn_busy || arrival;

   // ------------------------------------------------------------
   // crossing unit state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         QCG_DEV_STOPPED: begin
            // rising request is always granted
            if (int_qreq_n) begin
               nxt_state = QCG_DEV_RUN;
            end
         end
         QCG_DEV_RUN: begin
            if (!int_qreq_n) begin
               if (busy) begin
                  nxt_state = QCG_DEV_DENY;
               end else begin
                  nxt_state = QCG_DEV_STOPPED;
               end
            end
         end
         QCG_DEV_DENY: begin
            if (int_qreq_n) begin
               nxt_state = QCG_DEV_RUN;
            end
         end
         default: begin
            nxt_state = QCG_DEV_STOPPED;
         end
      endcase
   end

   // reset lands in stopped, isolated
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= QCG_DEV_STOPPED;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // boundary isolation
   // ------------------------------------------------------------
   // isolation set in the same edge as entering stopped
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         iso_ff <= 1'b1;
      end else begin
         iso_ff <= (nxt_state == QCG_DEV_STOPPED);
      end
   end

   // ------------------------------------------------------------
   // holding stage between the domains
   // ------------------------------------------------------------
   always_comb begin
      nxt_hold_v = hold_v_ff;
      if (take) begin
         nxt_hold_v = 1'b1;
      end else if (give) begin
         nxt_hold_v = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hold_v_ff <= 1'b0;
      end else begin
         hold_v_ff <= nxt_hold_v;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hold_d_ff <= '0;
      end else if (take) begin
         hold_d_ff <= up_data;
      end
   end

   // transactions stall at the boundary while stopped
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         up_ready_ff <= 1'b0;
      end else begin
         up_ready_ff <= (nxt_state != QCG_DEV_STOPPED) && !nxt_hold_v &&
                        up_ok_s;
      end
   end

   // ------------------------------------------------------------
   // domain clock control: q-channel answers
   // ------------------------------------------------------------
   // accept low on stop entry, high on run entry
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qaccept_n_ff <= QACCEPT_N_RST;
      end else if (state_ff == QCG_DEV_RUN &&
                   nxt_state == QCG_DEV_STOPPED) begin
         qaccept_n_ff <= 1'b0;
      end else if (state_ff == QCG_DEV_STOPPED &&
                   nxt_state == QCG_DEV_RUN) begin
         qaccept_n_ff <= 1'b1;
      end
   end

   // deny held until the request rises again
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qdeny_ff <= QDENY_RST;
      end else begin
         qdeny_ff <= (nxt_state == QCG_DEV_DENY);
      end
   end

   // wake-up toward clock control when arrival meets stopped domain
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= (state_ff == QCG_DEV_STOPPED) && arrival;
      end
   end

   // qactive: activity while running, wake-up while stopped
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qactive_ff <= QACTIVE_RST;
      end else begin
         case (nxt_state)
            QCG_DEV_RUN: begin
               qactive_ff <= busy;
            end
            QCG_DEV_DENY: begin
               qactive_ff <= 1'b1;
            end
            QCG_DEV_STOPPED: begin
               qactive_ff <= wake_ff || arrival;
            end
            default: begin
               qactive_ff <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign q.qaccept_n = qaccept_n_ff;
   assign q.qdeny = qdeny_ff;
   assign q.qactive = qactive_ff;
   assign up_ready = up_ready_ff;
   assign dn_valid = hold_v_ff;
   assign dn_data = hold_d_ff;
   assign isolated = iso_ff;
   assign wake = wake_ff;

endmodule : qcg_dev

// [design/qcg_if.sv]
// q-channel wires between the domain gating logic and its controller
interface qcg_if;
   logic qreq_n;
   logic qaccept_n;
   logic qdeny;
   logic qactive;

   modport dev (
      input qreq_n,
      output qaccept_n,
      output qdeny,
      output qactive
   );

   modport ctl (
      output qreq_n,
      input qaccept_n,
      input qdeny,
      input qactive
   );
endinterface : qcg_if

// [design/qcg_pkg.sv]
// package for the per-domain q-channel clock gating pair
// Operation
// - device drops qactive when domain idle
// - controller drops qreq_n only after qactive low
// - external request fall reaches crossing unit
// - idle crossing unit isolates and accepts on the same edge
// - controller gates clock only after acceptance
// - busy crossing unit raises qactive and denies
// - controller raises qreq_n after a denial
// - upstream arrival while stopped raises wake-up
// - wake-up drives external qactive high
// - controller restores clock before raising qreq_n
// - request rise removes isolation, accept transition
// - run requests are never denied
// - upstream leaves reset before wake flow
// - no upstream traffic before upstream ready
// - stopped domain isolated, transactions held
// - reset state is stopped and isolated
package qcg_pkg;

   // ------------------------------------------------------------
   // synchroniser and reset values
   // ------------------------------------------------------------
   localparam int SYNC_STAGES = 2;
   localparam logic QREQ_N_RST = 1'b0;
   localparam logic QACCEPT_N_RST = 1'b0;
   localparam logic QDENY_RST = 1'b0;
   localparam logic QACTIVE_RST = 1'b0;
   localparam logic CLK_EN_RST = 1'b0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int CLK_RESTORE_NS = 8;
   localparam int CLK_RESTORE_CYC =
      (CLK_RESTORE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESTORE_CNT_W = 4;

   // ------------------------------------------------------------
   // state machines
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      QCG_DEV_STOPPED,
      QCG_DEV_RUN,
      QCG_DEV_DENY
   } qcg_dev_st_t;

   typedef enum logic [2:0] {
      QCG_CTL_STOPPED,
      QCG_CTL_RESTORE,
      QCG_CTL_WAKE_REQ,
      QCG_CTL_RUN,
      QCG_CTL_STOP_REQ,
      QCG_CTL_DENIED
   } qcg_ctl_st_t;

endpackage : qcg_pkg

// [tb/qcg_chk.sv]
// concurrent checks on the q-channel wires between the two ends
module qcg_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // q-channel wires
   input wire logic qreq_n,
   input wire logic qaccept_n,
   input wire logic qdeny,
   input wire logic qactive
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // ------------------------------------------------------------
   // handshake steps
   // ------------------------------------------------------------
   sequence s_sync_hold;
      qaccept_n && !qdeny;
   endsequence
   sequence s_answer;
      !qaccept_n || qdeny;
   endsequence

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_reset_state;
      !$past(resetn) |-> !qaccept_n && !qdeny && !qreq_n;
   endproperty
   property p_stop_answer;
      $fell(qreq_n) |=> s_sync_hold ##[1:3] s_answer;
   endproperty
   property p_accept_fall;
      $fell(qaccept_n) |-> !qreq_n && $past(qreq_n, 3) == 1'b0;
   endproperty
   property p_accept_rise;
      $rose(qaccept_n) |-> qreq_n && $past(qreq_n, 3);
   endproperty
   property p_deny_cause;
      $rose(qdeny) |-> !qreq_n && qactive;
   endproperty
   property p_no_deny_run;
      qreq_n && $past(qreq_n, 4) |-> !qdeny;
   endproperty
   property p_run_answer;
      $rose(qreq_n) |-> ##[2:4] (qaccept_n && !qdeny);
   endproperty
   property p_wake;
      $rose(qactive) && !qaccept_n |-> ##[3:40] qreq_n;
   endproperty
   property p_stop_idle;
      $fell(qreq_n) |-> $past(qactive, 3) == 1'b0;
   endproperty

   a_reset_state: assert property (p_reset_state)
      else $error("q-channel not stopped after reset");
   a_stop_answer: assert property (p_stop_answer)
      else $error("stop request answered at wrong time");
   a_accept_fall: assert property (p_accept_fall)
      else $error("accept without stop request");
   a_accept_rise: assert property (p_accept_rise)
      else $error("accept released without run request");
   a_deny_cause: assert property (p_deny_cause)
      else $error("deny without stop request or activity");
   a_no_deny_run: assert property (p_no_deny_run)
      else $error("deny while run requested");
   a_run_answer: assert property (p_run_answer)
      else $error("run request not answered");
   a_wake: assert property (p_wake)
      else $error("wake not followed by run request");
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop requested while active");
endmodule : qcg_chk

// [tb/tb_clock_domain_qchannel_gating.sv]
// self-checking bench for the domain end and controller end together
module tb_clock_domain_qchannel_gating;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic up_ok = 1'b0;
   logic up_valid = 1'b0;
   logic [31:0] up_data = 32'h0;
   logic dn_ready = 1'b1;
   logic dn_busy = 1'b0;
   logic stop_want = 1'b0;
   logic up_ready, dn_valid, isolated, wake, clk_en, running, denied;
   logic [31:0] dn_data, exp_w;
   logic clk_en_q = 1'b0;
   logic wake_seen = 1'b0;
   logic stall_en = 1'b0;
   logic [31:0] exp_q[$];
   int n_errors = 0;
   int tests_run = 0;
   int k, c;

   always #2 mclk = ~mclk;

   // ------------------------------------------------------------
   // the two ends facing each other
   // ------------------------------------------------------------
   qcg_if q_if ();
   qcg_dev i_qcg_dev (.mclk(mclk), .resetn(resetn), .q(q_if.dev),
      .up_ok(up_ok), .up_valid(up_valid), .up_data(up_data),
      .up_ready(up_ready), .dn_valid(dn_valid), .dn_data(dn_data),
      .dn_ready(dn_ready), .dn_busy(dn_busy), .isolated(isolated),
      .wake(wake));
   qcg_ctl i_qcg_ctl (.mclk(mclk), .resetn(resetn), .q(q_if.ctl),
      .stop_want(stop_want), .clk_en(clk_en), .running(running),
      .denied(denied));
   qcg_chk i_qcg_chk (.mclk(mclk), .resetn(resetn),
      .qreq_n(q_if.qreq_n), .qaccept_n(q_if.qaccept_n),
      .qdeny(q_if.qdeny), .qactive(q_if.qactive));

   // ------------------------------------------------------------
   // compare and drive tasks
   // ------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   function automatic logic want_deny(input int n);
      return n % 2 == 1;
   endfunction : want_deny

   task automatic send(input logic [31:0] d);
      up_valid <= 1'b1;
      up_data <= d;
      for (k = 0; k < 100; k++) begin
         @(posedge mclk);
         if (up_ready === 1'b1) break;
      end
      chk_bit(up_ready, 1'b1);
      exp_q.push_back(d);
      up_valid <= 1'b0;
      @(posedge mclk);
   endtask : send

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // monitors: stream order, boundary hold, gating order
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      dn_ready <= stall_en ? 1'($urandom) : 1'b1;
   end

   always @(posedge mclk) begin
      if (resetn) begin
         if (dn_valid && dn_ready) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            chk_word(dn_data, exp_w);
         end
         if (isolated) chk_bit(up_ready, 1'b0);
         if (clk_en_q && !clk_en) chk_bit(q_if.qaccept_n, 1'b0);
         if (wake) wake_seen <= 1'b1;
         clk_en_q <= clk_en;
      end
   end

   // span well beyond the sum of all test phases
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(90));
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      chk_bit(isolated, 1'b1);
      chk_bit(running, 1'b0);
      chk_bit(clk_en, 1'b0);
      up_valid <= 1'b1;
      up_data <= 32'h0000_00a5;
      repeat (12) @(posedge mclk);
      chk_bit(wake_seen, 1'b0);
      chk_bit(up_ready, 1'b0);
      up_ok <= 1'b1;
      send(32'h0000_00a5);
      chk_bit(wake_seen, 1'b1);
      // accept needs two sync stages before the controller sees it
      for (k = 0; k < 20 && running !== 1'b1; k++) @(posedge mclk);
      chk_bit(running, 1'b1);
      $display("end of test: late upstream");
      for (c = 0; c < 6; c++) begin
         stall_en <= 1'b1;
         send(32'hffff_ffff);
         repeat (6) send($urandom);
         stall_en <= 1'b0;
         for (k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge mclk);
         stop_want <= 1'b1;
         for (k = 0; k < 50 && q_if.qreq_n !== 1'b0; k++) @(posedge mclk);
         chk_bit(q_if.qreq_n, 1'b0);
         dn_busy <= want_deny(c);
         for (k = 0; k < 100; k++) begin
            @(posedge mclk);
            if (denied === 1'b1 || clk_en === 1'b0) break;
         end
         chk_bit(denied, want_deny(c));
         chk_bit(q_if.qdeny, want_deny(c));
         chk_bit(q_if.qaccept_n, want_deny(c));
         chk_bit(clk_en, want_deny(c));
         chk_bit(isolated, !want_deny(c));
         stop_want <= 1'b0;
         dn_busy <= 1'b0;
         for (k = 0; k < 100 && running !== 1'b1; k++) @(posedge mclk);
         chk_bit(running, want_deny(c));
         $display("end of test: stop round %0d", c);
      end
      // domain reset again while upstream is ready and waiting
      resetn <= 1'b0;
      up_valid <= 1'b1;
      up_data <= 32'h0000_005a;
      repeat (4) @(posedge mclk);
      chk_bit(isolated, 1'b1);
      chk_bit(wake, 1'b0);
      chk_bit(q_if.qactive, 1'b0);
      chk_bit(up_ready, 1'b0);
      resetn <= 1'b1;
      send(32'h0000_005a);
      $display("end of test: reset with upstream pending");
      for (k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge mclk);
      chk_bit(exp_q.size() == 0, 1'b1);
      finish_test();
   end
endmodule : tb_clock_domain_qchannel_gating
